// ---- src/demod_defs.vh ----
// Constants for the receiver demodulator back end: register offsets, field positions,
// reset values and timing counts. Assumes APB byte addressing, one 32-bit word per register.
`ifndef DEMOD_DEFS_VH
`define DEMOD_DEFS_VH
// Register byte offsets
`define OFS_RATE_DIV 12'h000
`define OFS_SLICER 12'h004
`define OFS_CORR_CTRL 12'h008
`define OFS_FREQ_ERR 12'h00c
`define OFS_CORR_VAL 12'h010
`define OFS_CORR_BW 12'h014
`define OFS_LOW_IDX 12'h018
`define OFS_CARRIER 12'h01c
`define OFS_MODE 12'h020
// Reset values
`define RST_RATE_DIV 16'h1a0b
`define RST_FLOOR 8'h0c
`define RST_CARRIER 24'he4c000
`define RST_CORR_BW 8'h8b
`define RST_RX_BW 8'h55
// Slicer config fields
`define SL_FLOOR_LSB 0
`define SL_STEP_LSB 8
`define SL_PERIOD_LSB 11
`define SL_TYPE_LSB 14
// Threshold types
`define THR_FIXED 2'h0
`define THR_PEAK 2'h1
`define THR_AVG 2'h2
// Correction control bits
`define CC_START 0
`define CC_AUTO 1
`define CC_CLEAR 2
`define CC_DONE 3
`define CC_LOWIDX 4
// Mode register bits
`define MD_RX_EN 0
`define MD_PACKET 1
`define MD_SYNC_OFF 2
`define MD_USE_OOK 3
// 6 dB in half-decibel steps
`define PEAK_DROP 8'h0c
// Bit periods per measurement
`define MEAS_BITS 3'h4
`endif

// ---- src/peak_slicer.v ----
// On-off keying slicer with peak, fixed and average thresholds.
// Assumes strength samples arrive one per clock in half-decibel steps.
`timescale 1ns/1ns
`default_nettype none
`include "demod_defs.vh"
module peak_slicer (
   input wire clk,
   input wire rst,
   input wire [7:0] strength,
   input wire [1:0] thr_type,
   input wire [7:0] floor_level,
   input wire [2:0] decay_step,
   input wire [2:0] decay_period,
   output reg sliced
);
   reg [7:0] peak_r;
   reg [7:0] avg_r;
   reg [7:0] dec_cnt_r;
   wire [7:0] peak_thr;
   wire [7:0] thr;
   wire [7:0] step_w;
   wire [7:0] period_w;
   assign step_w = {4'h0, decay_step, 1'b0} + 8'h02;
   assign period_w = 8'h01 << decay_period;
   // Peak threshold is peak less 6 dB, clamped at zero
   assign peak_thr = (peak_r > `PEAK_DROP) ? (peak_r - `PEAK_DROP) : 8'h00;
   // Threshold selection
   assign thr = (thr_type == `THR_PEAK) ? ((peak_thr < floor_level) ? floor_level : peak_thr) :
                (thr_type == `THR_AVG) ? avg_r : floor_level;
   // Peak tracking with periodic decay toward the floor
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         peak_r <= 8'h00;
         dec_cnt_r <= 8'h00;
         avg_r <= 8'h00;
         sliced <= 1'b0;
      end else begin
         sliced <= (strength > thr);
         avg_r <= avg_r - {3'h0, avg_r[7:3]} + {3'h0, strength[7:3]};
         if (strength >= peak_r) begin
            peak_r <= strength;
            dec_cnt_r <= 8'h00;
         end else if (dec_cnt_r + 8'h01 >= period_w) begin
            dec_cnt_r <= 8'h00;
            if ({1'b0, peak_r} > {1'b0, floor_level} + {1'b0, step_w}) // Nine bits, no wrap near full scale
               peak_r <= peak_r - step_w;
            else
               peak_r <= floor_level;
         end else begin
            dec_cnt_r <= dec_cnt_r + 8'h01;
         end
      end
   end
endmodule // peak_slicer
`default_nettype wire

// ---- src/bit_sync.v ----
// Bit synchronizer: recovers clock and data from a raw bit stream.
// Assumes the divisor gives clock cycles per bit, at least 4.
`timescale 1ns/1ns
`default_nettype none
`include "demod_defs.vh"
module bit_sync (
   input wire clk,
   input wire rst,
   input wire [15:0] divisor,
   input wire raw_bit,
   output reg bit_tick,
   output reg data_out,
   output reg clk_out
);
   reg [15:0] phase_r;
   reg prev_r;
   wire [15:0] half_w;
   assign half_w = {1'b0, divisor[15:1]};
   // Phase counter nudged back to zero on each data edge
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_r <= 16'h0000;
         prev_r <= 1'b0;
         bit_tick <= 1'b0;
         data_out <= 1'b0;
         clk_out <= 1'b0;
      end else begin
         prev_r <= raw_bit;
         bit_tick <= 1'b0;
         if (raw_bit != prev_r)
            phase_r <= 16'h0000;
         else if (phase_r + 16'h0001 >= divisor)
            phase_r <= 16'h0000;
         else
            phase_r <= phase_r + 16'h0001;
         // Sample mid-bit, clock rises with data valid
         if (phase_r == half_w) begin
            data_out <= raw_bit;
            clk_out <= 1'b1;
            bit_tick <= 1'b1;
         end else if (phase_r == 16'h0000 && !bit_tick) begin // Never drop a clock raised one cycle ago
            clk_out <= 1'b0;
         end
      end
   end
endmodule // bit_sync
`default_nettype wire

// ---- src/rx_demod_bitsync_afc.v ----
// Receiver back end: APB registers, slicer, bit synchronizer, error estimate and correction.
// Assumes APB master in clk domain; demodulator and strength inputs synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
`include "demod_defs.vh"
module rx_demod_bitsync_afc (
   input wire clk,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire fsk_bit,
   input wire [7:0] strength,
   input wire signed [11:0] phase_err,
   output reg data_pin,
   output reg recovered_clock_pin,
   output reg [23:0] carrier_freq,
   output reg [7:0] filter_bw,
   output reg correcting
);
   // States
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_MEAS = 3'b010;
   localparam [2:0] ST_APPLY = 3'b100;
   reg [15:0] rate_divisor_reg;
   reg [15:0] slicer_peak_cfg_reg;
   reg [4:0] corr_ctrl_r;
   reg [15:0] freq_error_reg;
   reg [15:0] freq_correction_value;
   reg [7:0] correction_bandwidth_reg;
   reg [7:0] rx_bw_r;
   reg [7:0] low_index_offset_reg;
   reg [3:0] mode_r;
   reg [2:0] state_r;
   reg [2:0] bits_r;
   reg signed [15:0] acc_r;
   reg rx_en_d_r;
   reg done_r;
   wire sliced;
   wire sync_tick;
   wire sync_data;
   wire sync_clk;
   wire raw_bit;
   wire sync_on;
   wire seq_active;
   wire wr_w;
   wire auto_trig;
   wire start_trig;
   wire [15:0] corr_nxt;
   wire [31:0] rd_w;

   // Decode one register word by offset
   function [31:0] reg_word;
      input [11:0] a;
      begin
         case (a)
            `OFS_RATE_DIV: reg_word = {16'h0000, rate_divisor_reg};
            `OFS_SLICER: reg_word = {16'h0000, slicer_peak_cfg_reg};
            `OFS_CORR_CTRL: reg_word = {27'h0, corr_ctrl_r[4], done_r, corr_ctrl_r[2:1], 1'b0};
            `OFS_FREQ_ERR: reg_word = {16'h0000, freq_error_reg};
            `OFS_CORR_VAL: reg_word = {16'h0000, freq_correction_value};
            `OFS_CORR_BW: reg_word = {16'h0000, rx_bw_r, correction_bandwidth_reg};
            `OFS_LOW_IDX: reg_word = {24'h0, low_index_offset_reg};
            `OFS_CARRIER: reg_word = {8'h00, carrier_freq};
            `OFS_MODE: reg_word = {28'h0, mode_r};
            default: reg_word = 32'h0000_0000;
         endcase
      end
   endfunction

   // Address is mapped when aligned and known
   function mapped;
      input [11:0] a;
      begin
         mapped = (a[1:0] == 2'b00) && (a <= `OFS_MODE);
      end
   endfunction

   assign wr_w = psel && penable && pready && pwrite && mapped(paddr);
   assign rd_w = reg_word(paddr);

   // Demodulator selection: slicer for on-off keying, else frequency demodulator
   assign raw_bit = mode_r[`MD_USE_OOK] ? sliced : fsk_bit;
   // Synchronizer always on in packet mode, optional otherwise
   assign sync_on = mode_r[`MD_PACKET] || !mode_r[`MD_SYNC_OFF];

   peak_slicer u_slicer (
      .clk(clk),
      .rst(rst),
      .strength(strength),
      .thr_type(slicer_peak_cfg_reg[`SL_TYPE_LSB+1:`SL_TYPE_LSB]),
      .floor_level(slicer_peak_cfg_reg[`SL_FLOOR_LSB+7:`SL_FLOOR_LSB]),
      .decay_step(slicer_peak_cfg_reg[`SL_STEP_LSB+2:`SL_STEP_LSB]),
      .decay_period(slicer_peak_cfg_reg[`SL_PERIOD_LSB+2:`SL_PERIOD_LSB]),
      .sliced(sliced)
   );

   bit_sync u_sync (
      .clk(clk),
      .rst(rst),
      .divisor(rate_divisor_reg),
      .raw_bit(raw_bit),
      .bit_tick(sync_tick),
      .data_out(sync_data),
      .clk_out(sync_clk)
   );

   // Correction launch: auto on receive enable edge, else software start bit
   assign auto_trig = corr_ctrl_r[`CC_AUTO] && mode_r[`MD_RX_EN] && !rx_en_d_r;
   assign start_trig = !corr_ctrl_r[`CC_AUTO] && corr_ctrl_r[`CC_START];
   // Busy now or starting this cycle, so flag and bandwidth switch with any carrier undo
   assign seq_active = (state_r != ST_IDLE) || auto_trig || start_trig;
   // Correction value: error, plus low-index offset when enabled
   assign corr_nxt = corr_ctrl_r[`CC_LOWIDX] ?
                     (acc_r + {{8{low_index_offset_reg[7]}}, low_index_offset_reg}) : acc_r;

   // APB slave: one wait state, answer in access phase
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
         if (psel && penable && !pready) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_w;
            pslverr <= !mapped(paddr);
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

   // Configuration registers written by software
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rate_divisor_reg <= `RST_RATE_DIV;
         slicer_peak_cfg_reg <= {`THR_PEAK, 6'h00, `RST_FLOOR};
         correction_bandwidth_reg <= `RST_CORR_BW;
         rx_bw_r <= `RST_RX_BW;
         low_index_offset_reg <= 8'h00;
         mode_r <= 4'h0;
         rx_en_d_r <= 1'b0;
      end else begin
         rx_en_d_r <= mode_r[`MD_RX_EN];
         if (wr_w) begin
            case (paddr)
               `OFS_RATE_DIV: rate_divisor_reg <= pwdata[15:0];
               `OFS_SLICER: slicer_peak_cfg_reg <= pwdata[15:0];
               `OFS_CORR_BW: begin
                  correction_bandwidth_reg <= pwdata[7:0];
                  rx_bw_r <= pwdata[15:8];
               end
               `OFS_LOW_IDX: low_index_offset_reg <= pwdata[7:0];
               `OFS_MODE: mode_r <= pwdata[3:0];
               default: ;
            endcase
         end
      end
   end

   // Measurement and correction sequencer
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= ST_IDLE;
         bits_r <= 3'h0;
         acc_r <= 16'sh0000;
         corr_ctrl_r <= 5'h00;
         done_r <= 1'b0;
         freq_error_reg <= 16'h0000;
         freq_correction_value <= 16'h0000;
         carrier_freq <= `RST_CARRIER;
      end else begin
         // Control bits from software; start bit self-clears when taken
         if (wr_w && paddr == `OFS_CORR_CTRL) begin
            corr_ctrl_r <= {pwdata[`CC_LOWIDX], 1'b0, pwdata[`CC_CLEAR], pwdata[`CC_AUTO], pwdata[`CC_START]};
         end else if (state_r != ST_IDLE) begin
            corr_ctrl_r[`CC_START] <= 1'b0;
         end
         if (wr_w && paddr == `OFS_CORR_VAL)
            freq_correction_value <= pwdata[15:0];
         if (wr_w && paddr == `OFS_CARRIER)
            carrier_freq <= pwdata[23:0];
         if (wr_w && paddr == `OFS_CORR_CTRL && pwdata[`CC_DONE])
            done_r <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (auto_trig || start_trig) begin
                  state_r <= ST_MEAS;
                  bits_r <= 3'h0;
                  acc_r <= 16'sh0000;
                  if (auto_trig && corr_ctrl_r[`CC_CLEAR]) begin
                     // Undo the previous correction first
                     carrier_freq <= carrier_freq + {{8{freq_correction_value[15]}}, freq_correction_value};
                     freq_correction_value <= 16'h0000;
                  end
               end
            end
            ST_MEAS: begin
               if (sync_tick) begin
                  acc_r <= acc_r + {{4{phase_err[11]}}, phase_err};
                  if (bits_r == `MEAS_BITS - 3'h1)
                     state_r <= ST_APPLY;
                  bits_r <= bits_r + 3'h1;
               end
            end
            ST_APPLY: begin
               // Signed error in synthesizer steps
               freq_error_reg <= acc_r;
               freq_correction_value <= corr_nxt;
               carrier_freq <= carrier_freq - {{8{corr_nxt[15]}}, corr_nxt};
               done_r <= 1'b1;
               state_r <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Pin outputs and alternate bandwidth during correction
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         data_pin <= 1'b0;
         recovered_clock_pin <= 1'b0;
         filter_bw <= `RST_RX_BW;
         correcting <= 1'b0;
      end else begin
         data_pin <= sync_on ? sync_data : raw_bit;
         // Pin rises only on a fresh tick, so enabling the output mid-bit leaves no runt pulse
         recovered_clock_pin <= sync_on && (sync_tick || (recovered_clock_pin && sync_clk));
         filter_bw <= seq_active ? correction_bandwidth_reg : rx_bw_r;
         correcting <= seq_active;
      end
   end
endmodule // rx_demod_bitsync_afc
`default_nettype wire

// ---- testbench/demod_checks_properties.sv ----
// Checker for the receiver back end: register bus answers and output stability.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module demod_checks (
   input wire clk,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire recovered_clock_pin,
   input wire [23:0] carrier_freq,
   input wire [7:0] filter_bw,
   input wire correcting
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Steps of one register access
   sequence first_access;
      psel && penable && !$past(penable);
   endsequence
   sequence answer;
      pready && psel && penable;
   endsequence
   answer_wait_a: assert property (first_access |=> answer) else $error("no answer after access");
   ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
   ready_cause_a: assert property (pready |-> psel && penable) else $error("ready without access");
   err_with_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
   err_reads_zero_a: assert property (pslverr |-> prdata == 32'h0) else $error("refused read not zero");
   unaligned_err_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr) else $error("unaligned taken");
   unmapped_err_a: assert property (pready && paddr > 12'h020 |-> pslverr) else $error("unmapped taken");
   mapped_ok_a: assert property (pready && paddr[1:0] == 2'h0 && paddr <= 12'h020 |-> !pslverr)
      else $error("mapped refused");
   carrier_cause_a: assert property ($changed(carrier_freq) |-> correcting || $past(correcting)
      || (pwrite && (pready || $past(pready)))) else $error("carrier moved alone");
   bw_cause_a: assert property ($changed(filter_bw) |-> correcting != $past(correcting)
      || correcting != $past(correcting, 2) || $past(pready) || $past(pready, 2)) else $error("bandwidth moved alone");
   clock_width_a: assert property ($rose(recovered_clock_pin) |=> recovered_clock_pin)
      else $error("clock glitch");
endmodule // demod_checks
bind rx_demod_bitsync_afc demod_checks checks (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .recovered_clock_pin(recovered_clock_pin), .carrier_freq(carrier_freq), .filter_bw(filter_bw),
   .correcting(correcting));
`default_nettype wire

// ---- testbench/tx_model.sv ----
// Remote transmitter: alternating preamble at the bit rate, as FSK bit, strength and offset.
// Assumes bit_len equals the receiver divisor; when disabled, bit and offset lines change every cycle, strength stays zero.
`timescale 1ns/1ns
`default_nettype none
module tx_model (
   input wire logic clk,
   input wire logic en,
   input wire logic [15:0] bit_len,
   input wire logic signed [11:0] offset,
   output logic fsk_bit,
   output logic [7:0] strength,
   output logic signed [11:0] phase_err
);
   int cnt;
   initial begin
      cnt = 0;
      fsk_bit = 1'b0;
      phase_err = 12'sh000;
   end
   // Bit timer; alternating bits give a DC-free preamble with a transition every bit
   always @(posedge clk) begin
      if (!en) begin
         fsk_bit <= ~fsk_bit;
         strength <= 8'h00;
         phase_err <= ~phase_err;
         cnt <= 0;
      end else begin
         cnt <= (cnt + 1 >= bit_len) ? 0 : cnt + 1;
         if (cnt == 0) fsk_bit <= ~fsk_bit;
         strength <= fsk_bit ? 8'h60 : 8'h00;
         phase_err <= offset;
      end
   end
endmodule // tx_model
`default_nettype wire

// ---- testbench/rx_demod_bitsync_afc_tb.sv ----
// Testbench for the receiver back end: registers, correction, slicer and synchronizer.
// Assumes the design answers the bus with one wait state.
`timescale 1ns/1ns
`default_nettype none
module rx_demod_bitsync_afc_tb;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, se;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, fsk_bit, data_pin, recovered_clock_pin, correcting, tx_en = 1'b0, use_tx = 1'b0;
   logic [7:0] strength, tb_str = 8'h00, m_str, filter_bw;
   logic signed [11:0] phase_err, offset = 12'sh000;
   logic [23:0] carrier_freq;
   int mismatches = 0, checks_done = 0, seed = 21311, carrier, corr, err;
   assign strength = use_tx ? m_str : tb_str;
   rx_demod_bitsync_afc dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fsk_bit(fsk_bit),
      .strength(strength), .phase_err(phase_err), .data_pin(data_pin), .recovered_clock_pin(recovered_clock_pin),
      .carrier_freq(carrier_freq), .filter_bw(filter_bw), .correcting(correcting));
   tx_model partner (.clk(clk), .en(tx_en), .bit_len(16'h0008), .offset(offset), .fsk_bit(fsk_bit),
      .strength(m_str), .phase_err(phase_err));
   initial forever #25 clk = ~clk;
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic close_out;
      $display("Checks %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // A wait that ran out of cycles counts as a mismatch and ends the run
   task automatic limit(input int t, input int lim);
      if (t >= lim) begin
         mismatches++;
         close_out();
      end
   endtask
   // Setup, access, then hold until ready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int t;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (pready !== 1'b1 && t < 50);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (t >= 50) begin
         mismatches++;
         close_out();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] want);
      apb(1'b0, a, 32'h0);
      check(rd & mask, want & mask);
   endtask
   task automatic wait_pin(input logic want);
      int t;
      t = 0;
      while (data_pin !== want && t < 40) begin
         @(posedge clk);
         t++;
      end
      check(data_pin, want);
      limit(t, 40);
   endtask
   task automatic count_rises(input int want);
      int c;
      logic p;
      c = 0;
      p = recovered_clock_pin;
      repeat (160) begin
         @(posedge clk);
         if (recovered_clock_pin === 1'b1 && p === 1'b0) c++;
         p = recovered_clock_pin;
      end
      check(c >= want - 2 && c <= want + 2, 1'b1);
      $display("Test clock count done");
   endtask
   // Preamble, trigger, then compare error, correction and carrier with the model
   task automatic correct(input logic [11:0] ta, input logic [31:0] td, input int extra, input int back);
      int t;
      err = $random(seed) % 32;
      offset <= err[11:0];
      repeat (128) @(posedge clk);
      if (ta == 12'h020) wr(12'h020, 32'h0);
      wr(ta, td);
      t = 0;
      while (correcting !== 1'b1 && t < 40) begin
         @(posedge clk);
         t++;
      end
      limit(t, 40);
      t = 0;
      while (correcting === 1'b1 && t < 200) begin
         @(posedge clk);
         t++;
         if (correcting === 1'b1) check(filter_bw, 32'hc3);
      end
      limit(t, 200);
      corr = 4 * err + extra;
      carrier = (carrier + back - corr) & 32'hffffff;
      check(t >= 24 && t <= 48, 1'b1);
      repeat (2) @(posedge clk);
      check(carrier_freq, carrier);
      rchk(12'h00c, 32'hfff, 4 * err);
      rchk(12'h010, 32'hfff, corr);
      rchk(12'h008, 32'h8, 32'h8);
      check(filter_bw, 32'h44);
      $display("Test correction done");
   endtask
   // Main sequence
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      check(carrier_freq, 32'he4c000);
      check(filter_bw, 32'h55);
      rchk(12'h000, 32'hffff, 32'h1a0b);
      rchk(12'h004, 32'hff, 32'h0c);
      rchk(12'h014, 32'hff, 32'h8b);
      rchk(12'h01c, 32'hffffff, 32'he4c000);
      repeat (4) begin
         carrier = $random(seed) & 32'hffffff;
         wr(12'h01c, carrier);
         rchk(12'h01c, 32'hffffff, carrier);
         check(carrier_freq, carrier);
      end
      wr(12'h024, 32'hffffffff);
      check(se, 1'b1);
      rchk(12'h002, 32'hffffffff, 32'h0);
      check(se, 1'b1);
      wr(12'h000, 32'h0008);
      rchk(12'h000, 32'hffff, 32'h0008);
      check(se, 1'b0);
      $display("Test registers done");
      wr(12'h014, 32'h44c3);
      wr(12'h020, 32'h1);
      use_tx <= 1'b1;
      tx_en <= 1'b1;
      correct(12'h008, 32'h1, 0, 0);
      wr(12'h008, 32'ha);
      correct(12'h020, 32'h1, 0, 0);
      wr(12'h008, 32'he);
      correct(12'h020, 32'h1, 0, corr);
      wr(12'h008, 32'h0);
      wr(12'h018, 32'h3);
      correct(12'h008, 32'h19, 3, 0);
      use_tx <= 1'b0;
      tx_en <= 1'b0;
      wr(12'h020, 32'hd);
      wr(12'h004, 32'h0020);
      tb_str <= 8'h24;
      wait_pin(1'b1);
      tb_str <= 8'h1c;
      wait_pin(1'b0);
      check(recovered_clock_pin, 1'b0);
      wr(12'h004, 32'h7820);
      tb_str <= 8'h80;
      wait_pin(1'b1);
      tb_str <= 8'h76;
      repeat (10) @(posedge clk);
      wait_pin(1'b1);
      tb_str <= 8'h72;
      wait_pin(1'b0);
      wr(12'h004, 32'h4720);
      wait_pin(1'b1);
      tb_str <= 8'h00;
      repeat (200) @(posedge clk);
      tb_str <= 8'h1e;
      wait_pin(1'b0);
      tb_str <= 8'h22;
      wait_pin(1'b1);
      $display("Test slicer done");
      use_tx <= 1'b1;
      tx_en <= 1'b1;
      wr(12'h004, 32'h8020);
      wr(12'h020, 32'hf);
      count_rises(20);
      wr(12'h020, 32'h5);
      count_rises(0);
      close_out();
   end
endmodule // rx_demod_bitsync_afc_tb
`default_nettype wire
